// ===== design/feeder_control.sv
// softstarter feeder control with reverse interlock and resistive-load metering
`timescale 1ns/1ps
`default_nettype none
`include "feeder_regs.svh"

module feeder_control #(
  parameter int SEC_CYCLES = `SEC_TICK_CYCLES,
  parameter int MS_CYCLES  = `MS_TICK_CYCLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic [7:0]                    cmd_byte0,
  input  wire logic [7:0]                    cmd_byte1,
  input  wire logic                          digital_input_0,
  input  wire logic                          digital_input_1,
  input  wire logic                          digital_input_2,
  input  wire logic                          digital_input_3,
  input  wire logic                          digital_input_4,
  input  wire logic                          digital_input_5,
  input  wire logic                          local_control,
  input  wire logic                          overload_warning,
  input  wire logic                          aux3_is_fault_output,
  input  wire logic                          bypass_signal_available,
  input  wire logic                          resistive_load_enable,
  input  wire logic                          phase_loss_protection_enable,
  input  wire logic [feeder_pkg::TIME_W-1:0] reverse_lockout_time,
  input  wire logic [feeder_pkg::TIME_W-1:0] star_delta_start_time,
  input  wire logic [feeder_pkg::TIME_W-1:0] start_signal_delay,
  input  wire logic [feeder_pkg::CUR_W-1:0]  high_trip_level,
  input  wire logic [feeder_pkg::CUR_W-1:0]  high_warn_level,
  input  wire logic [feeder_pkg::CUR_W-1:0]  low_trip_level,
  input  wire logic [feeder_pkg::CUR_W-1:0]  low_warn_level,
  input  wire logic [6:0]                    imbalance_trip_level,
  input  wire logic [feeder_pkg::CUR_W-1:0]  i_l1,
  input  wire logic [feeder_pkg::CUR_W-1:0]  i_l2,
  input  wire logic [feeder_pkg::CUR_W-1:0]  i_l3,
  input  wire logic [feeder_pkg::VOLT_W-1:0] u_l1l2,
  input  wire logic [feeder_pkg::VOLT_W-1:0] u_l2l3,
  input  wire logic [feeder_pkg::VOLT_W-1:0] u_l3l1,
  input  wire logic [feeder_pkg::ANG_W-1:0]  ang_l1,
  input  wire logic [feeder_pkg::ANG_W-1:0]  ang_l2,
  input  wire logic [feeder_pkg::ANG_W-1:0]  ang_l3,
  output logic      [7:0]                    status_byte0,
  output logic      [7:0]                    status_byte1,
  output logic                               contactor_forward,
  output logic                               contactor_reverse,
  output logic                               softstarter_start,
  output logic                               aux_output_three,
  output logic                               emergency_start_prepared,
  output logic      [feeder_pkg::CUR_W-1:0]  thermal_model_current,
  output logic                               high_current_trip,
  output logic                               high_current_warn,
  output logic                               low_current_trip,
  output logic                               low_current_warn,
  output logic                               imbalance_trip,
  output logic      [6:0]                    current_imbalance,
  output logic      [15:0]                   power_factor,
  output logic      [feeder_pkg::PWR_W-1:0]  active_power
);

  feeder_pkg::ctrl_s s_reg;
  feeder_pkg::ctrl_s s_next;

  logic [feeder_pkg::CUR_W-1:0] i_max;
  logic [feeder_pkg::CUR_W-1:0] i_avg;
  logic [6:0]                   imb;
  logic                         sec_tick;
  logic                         ms_tick;
  logic                         run_fwd_req;
  logic                         run_rev_req;
  logic                         off_cmd;
  logic                         fault_reset;
  logic                         may_fwd;
  logic                         may_rev;
  logic                         running;
  logic                         trip_now;
  logic [feeder_pkg::CUR_W-1:0] prot_current;

  load_metering u_meter (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .i_l1         (i_l1),
    .i_l2         (i_l2),
    .i_l3         (i_l3),
    .u_l1l2       (u_l1l2),
    .u_l2l3       (u_l2l3),
    .u_l3l1       (u_l3l1),
    .ang_l1       (ang_l1),
    .ang_l2       (ang_l2),
    .ang_l3       (ang_l3),
    .i_max        (i_max),
    .i_avg        (i_avg),
    .imbalance    (imb),
    .power_factor (power_factor),
    .active_power (active_power)
  );

  always_comb begin
    s_next = s_reg;

    // free-running tick prescalers
    sec_tick = (s_reg.sec_pre == 32'(SEC_CYCLES - 1));
    ms_tick = (s_reg.ms_pre == 32'(MS_CYCLES - 1));
    s_next.sec_pre = sec_tick ? 32'h0 : s_reg.sec_pre + 32'h1;
    s_next.ms_pre = ms_tick ? 32'h0 : s_reg.ms_pre + 32'h1;

    // command decode; off wins, and contradicting run bits start nothing
    off_cmd = cmd_byte0[`CMD0_OFF];
    fault_reset = cmd_byte0[`CMD0_FAULT_RESET];
    run_fwd_req = cmd_byte0[`CMD0_AUTO_MODE] && cmd_byte0[`CMD0_RUN_FORWARD]
                  && !cmd_byte0[`CMD0_RUN_REVERSE] && !off_cmd;
    run_rev_req = cmd_byte0[`CMD0_AUTO_MODE] && cmd_byte0[`CMD0_RUN_REVERSE]
                  && !cmd_byte0[`CMD0_RUN_FORWARD] && !off_cmd;
    s_next.emergency_prep = cmd_byte0[`CMD0_EMERGENCY_PREP];

    // interlock: same direction free, opposite needs off plus elapsed lockout
    may_fwd = (s_reg.dir != feeder_pkg::DIR_REV)
              || (s_reg.off_seen && s_reg.lock_cnt == '0);
    may_rev = (s_reg.dir != feeder_pkg::DIR_FWD)
              || (s_reg.off_seen && s_reg.lock_cnt == '0);

    // protection current selection
    prot_current = resistive_load_enable ? i_max : i_avg;
    s_next.thermal_current = prot_current;
    running = (s_reg.state == feeder_pkg::ST_RUN) && s_reg.ramp_done;
    // checks held off during ramp so start inrush does not trip
    s_next.high_trip = running && (prot_current > high_trip_level);
    s_next.high_warn = running && (prot_current > high_warn_level);
    s_next.low_trip = running && (prot_current < low_trip_level);
    s_next.low_warn = running && (prot_current < low_warn_level);
    s_next.imb_trip = running && phase_loss_protection_enable
                      && (imb > imbalance_trip_level);
    trip_now = s_next.high_trip || s_next.low_trip || s_next.imb_trip;

    // fault latch: a trip in the reset cycle keeps the fault
    if (trip_now) begin
      s_next.fault = 1'b1;
    end else if (fault_reset) begin
      s_next.fault = 1'b0;
    end

    case (s_reg.state)
      feeder_pkg::ST_STOP: begin
        if (s_reg.lock_cnt != '0 && sec_tick) begin
          s_next.lock_cnt = s_reg.lock_cnt - 1'b1;
        end
        if (off_cmd) begin
          s_next.off_seen = 1'b1;
        end
        s_next.delay_cnt = '0;
        if (!s_reg.fault && run_fwd_req && may_fwd) begin
          s_next.state = feeder_pkg::ST_PRESTART;
          s_next.dir = feeder_pkg::DIR_FWD;
          s_next.off_seen = 1'b0;
          s_next.lock_cnt = '0;
        end else if (!s_reg.fault && run_rev_req && may_rev) begin
          s_next.state = feeder_pkg::ST_PRESTART;
          s_next.dir = feeder_pkg::DIR_REV;
          s_next.off_seen = 1'b0;
          s_next.lock_cnt = '0;
        end
      end
      feeder_pkg::ST_PRESTART: begin
        if (ms_tick) begin
          s_next.delay_cnt = s_reg.delay_cnt + 1'b1;
        end
        if (s_reg.delay_cnt >= start_signal_delay) begin
          s_next.state = feeder_pkg::ST_RUN;
          s_next.ramp_cnt = '0;
          s_next.ramp_done = 1'b0;
        end
      end
      feeder_pkg::ST_RUN: begin
        if (!s_reg.ramp_done) begin
          if (bypass_signal_available) begin
            s_next.ramp_done = digital_input_0;
          end else begin
            if (sec_tick) begin
              s_next.ramp_cnt = s_reg.ramp_cnt + 1'b1;
            end
            s_next.ramp_done = (s_reg.ramp_cnt >= star_delta_start_time);
          end
        end
      end
      default: begin
        s_next.state = feeder_pkg::ST_STOP;
      end
    endcase

    // stop by off command or fault; lockout starts counting from here
    if (s_reg.state != feeder_pkg::ST_STOP && (off_cmd || s_reg.fault)) begin
      s_next.state = feeder_pkg::ST_STOP;
      s_next.off_seen = off_cmd;
      s_next.lock_cnt = reverse_lockout_time;
      s_next.ramp_done = 1'b0;
    end

    // outputs, registered from the next state
    s_next.contactor_fwd = (s_next.state != feeder_pkg::ST_STOP)
                           && (s_next.dir == feeder_pkg::DIR_FWD);
    s_next.contactor_rev = (s_next.state != feeder_pkg::ST_STOP)
                           && (s_next.dir == feeder_pkg::DIR_REV);
    s_next.starter_run = (s_next.state == feeder_pkg::ST_RUN);
    s_next.aux3 = aux3_is_fault_output ? s_next.fault
                                       : cmd_byte1[`CMD1_AUX_OUTPUT_3];

    s_next.status0 = 8'h0;
    s_next.status0[`ST0_RUN_REVERSE] = s_next.contactor_rev;
    s_next.status0[`ST0_OFF] = (s_next.state == feeder_pkg::ST_STOP);
    s_next.status0[`ST0_RUN_FORWARD] = s_next.contactor_fwd;
    s_next.status0[`ST0_OVERLOAD_WARN] = overload_warning;
    s_next.status0[`ST0_LOCKOUT_ACTIVE] = (s_next.lock_cnt != '0);
    s_next.status0[`ST0_LOCAL_CONTROL] = local_control;
    s_next.status0[`ST0_SUMMARY_FAULT] = s_next.fault;
    s_next.status0[`ST0_SUMMARY_WARN] = overload_warning || s_next.high_warn
                                        || s_next.low_warn;
    s_next.status1 = {digital_input_5, digital_input_4, digital_input_3,
                      digital_input_2, digital_input_1, digital_input_0,
                      2'h0};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.status0 <= `STATUS0_RESET;
      s_reg.status1 <= `STATUS1_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign status_byte0 = s_reg.status0;
  assign status_byte1 = s_reg.status1;
  assign contactor_forward = s_reg.contactor_fwd;
  assign contactor_reverse = s_reg.contactor_rev;
  assign softstarter_start = s_reg.starter_run;
  assign aux_output_three = s_reg.aux3;
  assign emergency_start_prepared = s_reg.emergency_prep;
  assign thermal_model_current = s_reg.thermal_current;
  assign high_current_trip = s_reg.high_trip;
  assign high_current_warn = s_reg.high_warn;
  assign low_current_trip = s_reg.low_trip;
  assign low_current_warn = s_reg.low_warn;
  assign imbalance_trip = s_reg.imb_trip;
  assign current_imbalance = imb;

endmodule // feeder_control
`default_nettype wire

// ===== design/feeder_regs.svh
// bit positions, reset values and timing counts of the feeder control block
`ifndef FEEDER_REGS_SVH
`define FEEDER_REGS_SVH

// command byte 0
`define CMD0_RUN_REVERSE     0
`define CMD0_OFF             1
`define CMD0_RUN_FORWARD     2
`define CMD0_EMERGENCY_PREP  4
`define CMD0_AUTO_MODE       5
`define CMD0_FAULT_RESET     6
// command byte 1
`define CMD1_AUX_OUTPUT_3    4

// status byte 0
`define ST0_RUN_REVERSE      0
`define ST0_OFF              1
`define ST0_RUN_FORWARD      2
`define ST0_OVERLOAD_WARN    3
`define ST0_LOCKOUT_ACTIVE   4
`define ST0_LOCAL_CONTROL    5
`define ST0_SUMMARY_FAULT    6
`define ST0_SUMMARY_WARN     7
// status byte 1: inputs 0..5 start here
`define ST1_INPUT_BASE       2

// reset values
`define STATUS0_RESET        8'h02
`define STATUS1_RESET        8'h00

// timing: clock rate and tick lengths
`define CLK_SYS_HZ           20000000
`define SEC_TICK_S           1
`define MS_TICK_MS           1
`define SEC_TICK_CYCLES      (`CLK_SYS_HZ * `SEC_TICK_S)
`define MS_TICK_CYCLES       (`CLK_SYS_HZ / 1000 * `MS_TICK_MS)

// metering constants
`define COS_K                17'h07e90
`define ANGLE_MAX_DEG        8'h5a
`define INV_SQRT3_Q16        16'h93cd
`define PERCENT_SCALE        7'h64

`endif

// ===== design/feeder_pkg.sv
// types of the feeder control and load metering block
package feeder_pkg;

  localparam int CUR_W = 16;
  localparam int VOLT_W = 16;
  localparam int ANG_W = 8;
  localparam int PWR_W = 40;
  localparam int TIME_W = 16;

  typedef enum logic [1:0] {
    ST_STOP     = 2'b00,
    ST_PRESTART = 2'b01,
    ST_RUN      = 2'b10
  } run_state_e;

  typedef enum logic [1:0] {
    DIR_NONE = 2'b00,
    DIR_FWD  = 2'b01,
    DIR_REV  = 2'b10
  } dir_e;

  typedef struct packed {
    logic [CUR_W-1:0]  i_max;
    logic [CUR_W-1:0]  i_min;
    logic [CUR_W-1:0]  i_avg;
    logic [CUR_W+1:0]  i_sum;
    logic [VOLT_W+1:0] u_sum;
    logic [15:0]       power_factor;
    logic [6:0]        imbalance;
    logic [PWR_W-1:0]  active_power;
  } meter_s;

  typedef struct packed {
    run_state_e        state;
    dir_e              dir;
    logic              off_seen;
    logic [TIME_W-1:0] lock_cnt;
    logic [31:0]       sec_pre;
    logic [31:0]       ms_pre;
    logic [TIME_W-1:0] delay_cnt;
    logic [TIME_W-1:0] ramp_cnt;
    logic              ramp_done;
    logic              fault;
    logic [7:0]        status0;
    logic [7:0]        status1;
    logic              contactor_fwd;
    logic              contactor_rev;
    logic              starter_run;
    logic              aux3;
    logic              emergency_prep;
    logic [CUR_W-1:0]  thermal_current;
    logic              high_trip;
    logic              high_warn;
    logic              low_trip;
    logic              low_warn;
    logic              imb_trip;
  } ctrl_s;

endpackage

// ===== design/load_metering.sv
// phase current extremes, imbalance, power factor and active power
`timescale 1ns/1ps
`default_nettype none
`include "feeder_regs.svh"

module load_metering (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_b,
  input  wire logic [feeder_pkg::CUR_W-1:0]  i_l1,
  input  wire logic [feeder_pkg::CUR_W-1:0]  i_l2,
  input  wire logic [feeder_pkg::CUR_W-1:0]  i_l3,
  input  wire logic [feeder_pkg::VOLT_W-1:0] u_l1l2,
  input  wire logic [feeder_pkg::VOLT_W-1:0] u_l2l3,
  input  wire logic [feeder_pkg::VOLT_W-1:0] u_l3l1,
  input  wire logic [feeder_pkg::ANG_W-1:0]  ang_l1,
  input  wire logic [feeder_pkg::ANG_W-1:0]  ang_l2,
  input  wire logic [feeder_pkg::ANG_W-1:0]  ang_l3,
  output logic      [feeder_pkg::CUR_W-1:0]  i_max,
  output logic      [feeder_pkg::CUR_W-1:0]  i_avg,
  output logic      [6:0]                    imbalance,
  output logic      [15:0]                   power_factor,
  output logic      [feeder_pkg::PWR_W-1:0]  active_power
);

  feeder_pkg::meter_s m_reg;
  feeder_pkg::meter_s m_next;

  logic [9:0]  ang_sum;
  logic [7:0]  ang_avg;
  logic [15:0] ang_sq;
  logic [16:0] cos_num;
  logic [16:0] cos_den;
  logic [31:0] cos_q;
  logic [35:0] vi_prod;
  logic [67:0] p_full;
  logic [67:0] p_shift;
  logic [15:0] i_diff;
  logic [22:0] diff_pct;

  always_comb begin
    m_next = m_reg;
    // stage 1: extremes, sums and power factor
    m_next.i_max = (i_l1 >= i_l2) ? ((i_l1 >= i_l3) ? i_l1 : i_l3)
                                  : ((i_l2 >= i_l3) ? i_l2 : i_l3);
    m_next.i_min = (i_l1 <= i_l2) ? ((i_l1 <= i_l3) ? i_l1 : i_l3)
                                  : ((i_l2 <= i_l3) ? i_l2 : i_l3);
    m_next.i_sum = {2'h0, i_l1} + {2'h0, i_l2} + {2'h0, i_l3};
    m_next.i_avg = 16'(m_next.i_sum / 18'h3);
    m_next.u_sum = {2'h0, u_l1l2} + {2'h0, u_l2l3} + {2'h0, u_l3l1};
    // angles are magnitudes already; capacitive loads are not supported
    ang_sum = {2'h0, ang_l1} + {2'h0, ang_l2} + {2'h0, ang_l3};
    ang_avg = 8'(ang_sum / 10'h3);
    if (ang_avg > `ANGLE_MAX_DEG) begin
      ang_avg = `ANGLE_MAX_DEG;
    end
    ang_sq = {8'h0, ang_avg} * {8'h0, ang_avg};
    // rational cosine, error well under one percent over 0..90 degrees
    cos_num = `COS_K - {ang_sq[14:0], 2'h0};
    cos_den = `COS_K + {1'h0, ang_sq};
    cos_q = {cos_num, 15'h0} / {15'h0, cos_den};
    m_next.power_factor = cos_q[15:0];
    // stage 2: power and imbalance from the stage 1 registers
    vi_prod = {18'h0, m_reg.i_sum} * {18'h0, m_reg.u_sum};
    p_full = {32'h0, vi_prod} * {52'h0, m_reg.power_factor} * {52'h0, `INV_SQRT3_Q16};
    p_shift = p_full >> 31;
    m_next.active_power = 40'(p_shift / 68'h3);
    i_diff = m_reg.i_max - m_reg.i_min;
    diff_pct = {7'h0, i_diff} * {16'h0, `PERCENT_SCALE};
    if (m_reg.i_max == 16'h0) begin
      m_next.imbalance = 7'h0;
    end else begin
      m_next.imbalance = 7'(diff_pct / {7'h0, m_reg.i_max});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      m_reg <= '0;
    end else begin
      m_reg <= m_next;
    end
  end

  assign i_max = m_reg.i_max;
  assign i_avg = m_reg.i_avg;
  assign imbalance = m_reg.imbalance;
  assign power_factor = m_reg.power_factor;
  assign active_power = m_reg.active_power;

endmodule // load_metering
`default_nettype wire

// ===== sim/feeder_control_assertions.sv
// concurrent checks on the feeder control ports
`timescale 1ns/1ps
`default_nettype none
module feeder_control_chk (
  input wire logic                           clk_sys,
  input wire logic                           rst_b,
  input wire logic [7:0]                     cmd_byte0,
  input wire logic [7:0]                     cmd_byte1,
  input wire logic                           digital_input_0,
  input wire logic                           digital_input_1,
  input wire logic                           digital_input_2,
  input wire logic                           digital_input_3,
  input wire logic                           digital_input_4,
  input wire logic                           digital_input_5,
  input wire logic                           aux3_is_fault_output,
  input wire logic                           resistive_load_enable,
  input wire logic                           phase_loss_protection_enable,
  input wire logic [feeder_pkg::TIME_W-1:0]  start_signal_delay,
  input wire logic [feeder_pkg::CUR_W-1:0]   i_l1,
  input wire logic [feeder_pkg::CUR_W-1:0]   i_l2,
  input wire logic [feeder_pkg::CUR_W-1:0]   i_l3,
  input wire logic [7:0]                     status_byte0,
  input wire logic [7:0]                     status_byte1,
  input wire logic                           contactor_forward,
  input wire logic                           contactor_reverse,
  input wire logic                           softstarter_start,
  input wire logic                           aux_output_three,
  input wire logic [feeder_pkg::CUR_W-1:0]   thermal_model_current,
  input wire logic                           imbalance_trip
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [5:0]                    di_vec;
  logic [feeder_pkg::CUR_W-1:0]  imax_c;
  logic                          last_fwd_reg;
  assign di_vec = {digital_input_5, digital_input_4, digital_input_3,
                   digital_input_2, digital_input_1, digital_input_0};
  always_comb begin
    imax_c = i_l1;
    if (i_l2 > imax_c) imax_c = i_l2;
    if (i_l3 > imax_c) imax_c = i_l3;
  end
  // remembers whether the last run was forward, so reversal can be told from restart
  always_ff @(posedge clk_sys) begin
    if (!rst_b) last_fwd_reg <= 1'b0;
    else if (contactor_forward) last_fwd_reg <= 1'b1;
    else if (contactor_reverse) last_fwd_reg <= 1'b0;
  end
  a_off_bit: assert property (status_byte0[1] == !(contactor_forward || contactor_reverse))
    else $error("off bit disagrees with contactors");
  a_run_bits: assert property ({status_byte0[2], status_byte0[0]} ==
    {contactor_forward, contactor_reverse}) else $error("run bits disagree");
  a_input_mirror: assert property ($past(rst_b) |-> status_byte1 == {$past(di_vec), 2'b00})
    else $error("inputs not mirrored");
  a_aux_follow: assert property ($past(rst_b) && !$past(aux3_is_fault_output) |->
    aux_output_three == $past(cmd_byte1[4])) else $error("aux output ignores command");
  a_off_wins: assert property ($past(rst_b) && $past(cmd_byte0[1]) |->
    !contactor_forward && !contactor_reverse) else $error("off not obeyed");
  a_no_dual_run: assert property ($past(cmd_byte0[0] && cmd_byte0[2]) |->
    !$rose(contactor_forward) && !$rose(contactor_reverse)) else $error("dual run taken");
  a_rev_lockout: assert property ($rose(contactor_reverse) && last_fwd_reg |->
    !$past(status_byte0[4])) else $error("reversal inside lockout");
  a_start_delay: assert property ($rose(contactor_forward) && start_signal_delay == 16'h0 |->
    !softstarter_start ##1 (softstarter_start || !contactor_forward))
    else $error("softstarter start timing");
  a_thermal_max: assert property ($past(rst_b) && $past(rst_b, 2) &&
    $past(resistive_load_enable) && $past(resistive_load_enable, 2) |->
    thermal_model_current == $past(imax_c, 2)) else $error("thermal current not max");
  a_imb_off: assert property (!$past(phase_loss_protection_enable) |-> !imbalance_trip)
    else $error("imbalance trip while disabled");
endmodule // feeder_control_chk
bind feeder_control feeder_control_chk u_chk (.*);
`default_nettype wire

// ===== sim/fieldbus_master.sv
// behavioural fieldbus master driving the command bytes
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master (
  input  wire logic        clk_sys,
  output var  logic [7:0]  cmd_byte0,
  output var  logic [7:0]  cmd_byte1
);
  initial begin
    cmd_byte0 = 8'h00;
    cmd_byte1 = 8'h00;
  end
  // f = {aux, reset, auto, emergency, fwd, off, rev}; unused bits always sent as 0
  task automatic send(input logic [6:0] f, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    cmd_byte0 <= {1'b0, f[5], f[4], f[3], 1'b0, f[2], f[1], f[0]};
    cmd_byte1 <= {3'h0, f[6], 4'h0};
  endtask
endmodule // fieldbus_master
`default_nettype wire

// ===== sim/tb_feeder_control.sv
// self-checking bench for the feeder control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: case %0d got %0h expected %0h", $time, s.sel, g, e); end end
module tb_feeder_control;
  typedef struct {int sel; logic [39:0] val;} note_s;
  logic clk_sys, rst_b, local_control, overload_warning, aux3_is_fault_output;
  logic bypass_signal_available, resistive_load_enable, phase_loss_protection_enable;
  logic digital_input_0, digital_input_1, digital_input_2, digital_input_3;
  logic digital_input_4, digital_input_5, contactor_forward, contactor_reverse, flag;
  logic softstarter_start, aux_output_three, emergency_start_prepared, imbalance_trip;
  logic high_current_trip, high_current_warn, low_current_trip, low_current_warn;
  logic [7:0]  cmd_byte0, cmd_byte1, status_byte0, status_byte1, ang_l1, ang_l2, ang_l3;
  logic [6:0]  imbalance_trip_level, current_imbalance;
  logic [15:0] reverse_lockout_time, star_delta_start_time, start_signal_delay, power_factor;
  logic [15:0] high_trip_level, high_warn_level, low_trip_level, low_warn_level;
  logic [15:0] thermal_model_current, i_l1, i_l2, i_l3, u_l1l2, u_l2l3, u_l3l1, v, c[3];
  logic [7:0]  a[3];
  logic [39:0] active_power, got;
  note_s       exp_q[$];
  note_s       s;
  int          error_cnt, checks_done, n, k, mx, mn, sm;
  integer      seed;
  real         pfr;
  feeder_control #(.SEC_CYCLES(20), .MS_CYCLES(4)) DUT (.*);
  fieldbus_master FB (.*);
  always #25 clk_sys = ~clk_sys;
  function automatic logic [39:0] near(logic [39:0] g, logic [39:0] e, logic [39:0] t);
    return (((g > e) ? g - e : e - g) <= t) ? e : g;
  endfunction
  task automatic step(int m);
    repeat (m) @(posedge clk_sys);
  endtask
  task automatic push(int sel, logic [39:0] val);
    exp_q.push_back('{sel, val});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // settled outputs are compared half a cycle after each edge
  always @(negedge clk_sys) begin
    while (exp_q.size() > 0) begin
      s = exp_q.pop_front();
      case (s.sel)
        0: got = status_byte0;
        1: got = status_byte1;
        2: got = aux_output_three;
        3: got = contactor_forward;
        4: got = contactor_reverse;
        5: got = softstarter_start;
        6: got = thermal_model_current;
        7: got = emergency_start_prepared;
        8: got = {high_current_trip, high_current_warn, low_current_trip, low_current_warn,
                  imbalance_trip};
        9: got = near(power_factor, s.val, 40'd120);
        10: got = near(current_imbalance, s.val, 40'd1);
        11: got = near(active_power, s.val, s.val / 100 + 2);
        12: got = near(thermal_model_current, s.val, 40'd1);
        default: got = flag;
      endcase
      `CHK(got, s.val)
    end
  end
  // whole run is under two hundred cycles; this bound is 5000 cycles
  initial begin
    #(5000 * 50);
    error_cnt++;
    close_out();
  end
  initial begin
    clk_sys = 0; rst_b = 0; seed = 32'hd6603f39; flag = 0;
    {digital_input_5, digital_input_4, digital_input_3} = 3'h0;
    {digital_input_2, digital_input_1, digital_input_0} = 3'h0;
    {local_control, overload_warning, aux3_is_fault_output} = 3'h0;
    {bypass_signal_available, resistive_load_enable, phase_loss_protection_enable} = 3'h0;
    reverse_lockout_time = 16'h2; star_delta_start_time = 16'h2; start_signal_delay = 16'h0;
    high_trip_level = 16'hffff; high_warn_level = 16'hffff;
    low_trip_level = 16'h0; low_warn_level = 16'h0; imbalance_trip_level = 7'h64;
    {i_l1, i_l2, i_l3, u_l1l2, u_l2l3, u_l3l1} = '0; {ang_l1, ang_l2, ang_l3} = '0;
    step(3); push(0, 8'h02); push(1, 8'h00);
    rst_b <= 1'b1;
    step(1); n = $random(seed);
    {digital_input_5, digital_input_4, digital_input_3, digital_input_2,
     digital_input_1, digital_input_0} <= n[5:0];
    {local_control, overload_warning} <= 2'h3;
    step(1); push(1, {n[5:0], 2'b00}); push(0, 8'haa);
    {local_control, overload_warning, digital_input_0} <= 3'h0;
    $display("status test done");
    for (k = 0; k < 4; k++) begin
      FB.send({k[0], 6'h0}, 0); aux3_is_fault_output <= k[1];
      step(1); push(2, k[1] ? 1'b0 : k[0]);
    end
    FB.send(7'h04, 0); step(2); push(3, 0);
    FB.send(7'h08, 0); step(1); push(7, 1);
    $display("command test done");
    FB.send(7'h14, 0); step(1); push(3, 1); push(0, 8'h04); push(5, 0);
    step(2); push(5, 1);
    FB.send(7'h12, 0); step(1); push(3, 0); push(5, 0); push(0, 8'h12);
    FB.send(7'h11, 0); step(3); push(4, 0);
    FB.send(7'h14, 1); step(1); push(3, 1);
    FB.send(7'h12, 0); FB.send(7'h11, 0);
    for (n = 0; contactor_reverse !== 1'b1 && n < 100; n++) @(negedge clk_sys);
    flag = (n >= 19 && n <= 44); push(15, 1);
    $display("interlock test done");
    @(posedge clk_sys);
    {i_l1, i_l2, i_l3} <= {16'd200, 16'd150, 16'd120}; high_trip_level <= 16'd180;
    high_warn_level <= 16'd190; low_warn_level <= 16'd250; imbalance_trip_level <= 7'd30;
    resistive_load_enable <= 1'b1; phase_loss_protection_enable <= 1'b1;
    for (n = 0; high_current_trip !== 1'b1 && n < 100; n++) @(negedge clk_sys);
    flag = (n >= 15 && n <= 45); push(15, 1); push(8, 5'h1b);
    step(3); push(4, 0); push(5, 0); push(0, 8'h52); push(2, 1);
    {i_l1, i_l2, i_l3} <= {3{16'd50}};
    FB.send(7'h30, 0); step(2); push(0, 8'h12);
    $display("protection test done");
    for (k = 0; k < 6; k++) begin
      foreach (c[j]) c[j] = 16'(1 + {$random(seed)} % 1000);
      foreach (a[j]) a[j] = 8'({$random(seed)} % 61);
      v = 16'(300 + {$random(seed)} % 200);
      @(posedge clk_sys);
      {i_l1, i_l2, i_l3, u_l1l2, u_l2l3, u_l3l1} <= {c[0], c[1], c[2], v, v, v};
      {ang_l1, ang_l2, ang_l3} <= {a[0], a[1], a[2]};
      {resistive_load_enable, bypass_signal_available} <= k[1:0];
      phase_loss_protection_enable <= k[2];
      mx = c[0]; mn = c[0]; sm = c[0] + c[1] + c[2];
      foreach (c[j]) begin
        if (c[j] > mx) mx = c[j];
        if (c[j] < mn) mn = c[j];
      end
      pfr = $cos(((a[0] + a[1] + a[2]) / 3) * 3.14159265 / 180.0);
      step(3); push(k[1] ? 6 : 12, k[1] ? mx : sm / 3);
      push(10, $rtoi(100.0 * (1.0 - real'(mn) / mx) + 0.5));
      push(9, $rtoi(pfr * 32768.0));
      push(11, $rtoi(real'(sm) * v * pfr / $sqrt(3.0)));
    end
    $display("metering test done");
    step(2);
    close_out();
  end
endmodule // tb_feeder_control
`default_nettype wire
